// [hw/tofc_core.sv]
/*
  tofc_core: counting core of a stopwatch time converter. A wrap counter
  of the ring oscillator forms the fine results, a cycle counter of the
  reference clock forms the long-range results, both are checked against
  16-bit limits that flag an overflow and halt the measurement.
  Assumes start, stop, reference clock, ring wrap toggle, ring phase and
  enable arrive asynchronously; registers are reached over a plain port.
*/
// How it works
// R1: ring wraps are counted; wrap count and phase form six fine results.
// R2: in long-range mode whole reference cycles are counted from start to stops.
// R3: one cycle count result is kept per stop, up to five.
// R4: wrap overflow flag sets when wrap count reaches the wrap limit.
// R5: wrap limit is high byte times 256 plus low byte.
// R6: cycle overflow flag sets when cycle count exceeds the cycle limit.
// R7: cycle limit is high byte times 256 plus low byte.
// R8: any overflow ends the running measurement at once.
// R9: host keeps the reference clock running while enabled.
// R10: in long-range mode reference clock edges bound the fine time intervals.
// R11: host waits about 300 us after enable before measuring.
// R12: inputs are taken on rising edges, outputs change afterwards.
// R13: enable low clears all digital state except the pin synchronisers and edge finders.
// R14: overflow flags hold until cleared by software or a new start.
`timescale 1ns/1ns
module tofc_core #(
  parameter int WAKE_CYC = tofc_pkg::WAKE_CYCLES
) (
  input wire logic clk_i,                                  // core clock
  input wire logic reset_i,                                // async reset
  input wire logic enable_i,                               // enable pin
  input wire logic start_i,                                // start pulse pin
  input wire logic stop_i,                                 // stop pulse pin
  input wire logic ref_clk_i,                              // reference clock pin
  input wire logic ring_wrap_i,                            // toggles per ring wrap
  input wire logic [tofc_pkg::PHASE_W-1:0] ring_phase_i,   // ring tap position
  input wire logic [tofc_pkg::ADDR_W-1:0] reg_addr_i,      // register address
  input wire logic [tofc_pkg::DATA_W-1:0] reg_wdata_i,     // write data
  input wire logic reg_we_i,                               // write strobe
  input wire logic reg_re_i,                               // read strobe
  output logic [tofc_pkg::DATA_W-1:0] reg_rdata_o,         // read data
  output logic irq_o                                       // interrupt, high
);
  import tofc_pkg::*;

  logic [4:0] pins_s;
  logic [PHASE_W-1:0] phase_s;
  logic en_s;
  logic start_s;
  logic stop_s;
  logic ref_s;
  logic wrap_s;
  logic start_d_r;
  logic stop_d_r;
  logic ref_d_r;
  logic wrap_d_r;
  logic start_rise;
  logic stop_rise;
  logic ref_rise;
  logic wrap_tick;
  logic clr;

  logic ctrl_mode_r;
  logic [IDX_W-1:0] ctrl_nstop_r;
  logic [BYTE_W-1:0] wrap_lim_high_r;
  logic [BYTE_W-1:0] wrap_lim_low_r;
  logic [BYTE_W-1:0] cyc_lim_high_r;
  logic [BYTE_W-1:0] cyc_lim_low_r;
  logic [INT_W-1:0] int_status_r;
  logic [INT_W-1:0] int_mask_r;
  logic [DATA_W-1:0] rdata_r;

  tofc_state_type state_r;
  tofc_state_type state_nxt;
  logic [LIM_W-1:0] wrap_cnt_r;
  logic [LIM_W-1:0] cyc_cnt_r;
  logic clk_run_r;
  logic [IDX_W-1:0] fine_idx_r;
  logic [IDX_W-1:0] stop_idx_r;
  logic [FINE_W-1:0] fine_res_r [NUM_FINE];
  logic [LIM_W-1:0] cyc_res_r [NUM_STOP];
  logic [31:0] wake_cnt_r;
  logic ready_r;

  logic meas_go;
  logic ring_on;
  logic wrap_hit;
  logic cyc_hit;
  logic ovf;
  logic fine_latch;
  logic cyc_latch;
  logic last_fine;
  logic done_ev;
  logic [IDX_W-1:0] num_stop;
  logic [FINE_W-1:0] fine_now;
  logic [INT_W-1:0] int_ev;
  logic [INT_W-1:0] int_w1c;
  logic [ADDR_W-1:0] fine_ofs;
  logic [ADDR_W-1:0] cyc_ofs;

  // pin synchronisers
  tofc_sync #(.W(5)) u_pin_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i({enable_i, start_i, stop_i, ref_clk_i, ring_wrap_i}),
    .q_o(pins_s)
  );

  tofc_sync #(.W(PHASE_W)) u_phase_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i(ring_phase_i),
    .q_o(phase_s)
  );

  assign en_s = pins_s[4];
  assign start_s = pins_s[3];
  assign stop_s = pins_s[2];
  assign ref_s = pins_s[1];
  assign wrap_s = pins_s[0];

  assign clr = ~en_s; // R13

  // edge finders on synchronised pins
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      start_d_r <= 1'b0;
      stop_d_r <= 1'b0;
      ref_d_r <= 1'b0;
      wrap_d_r <= 1'b0;
    end else begin
      start_d_r <= start_s;
      stop_d_r <= stop_s;
      ref_d_r <= ref_s;
      wrap_d_r <= wrap_s;
    end
  end

  assign start_rise = start_s & ~start_d_r;
  assign stop_rise = stop_s & ~stop_d_r;
  assign ref_rise = ref_s & ~ref_d_r;
  assign wrap_tick = wrap_s ^ wrap_d_r;

  // settle timer after enable
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wake_cnt_r <= '0;
      ready_r <= 1'b0;
    end else if (clr) begin
      wake_cnt_r <= '0;
      ready_r <= 1'b0;
    end else if (wake_cnt_r >= 32'(WAKE_CYC - 1)) begin
      ready_r <= 1'b1; // R11
    end else begin
      wake_cnt_r <= wake_cnt_r + 32'h00000001;
    end
  end

  // stop count clamped to 1..5
  assign num_stop = (ctrl_nstop_r == 3'h0) ? 3'h1 :
                    (ctrl_nstop_r > 3'(NUM_STOP)) ? 3'(NUM_STOP) : ctrl_nstop_r;

  assign meas_go = reg_we_i & (reg_addr_i == OFS_CTRL) & reg_wdata_i[CTRL_GO_BIT];
  assign ring_on = (state_r == TOFC_RING);

  tofc_limit_cmp #(.STRICT(1'b0)) u_wrap_cmp (
    .active_i(ring_on),
    .count_i(wrap_cnt_r),
    .limit_high_i(wrap_lim_high_r),
    .limit_low_i(wrap_lim_low_r),
    .hit_o(wrap_hit)
  ); // R4 R5

  tofc_limit_cmp #(.STRICT(1'b1)) u_cyc_cmp (
    .active_i(clk_run_r),
    .count_i(cyc_cnt_r),
    .limit_high_i(cyc_lim_high_r),
    .limit_low_i(cyc_lim_low_r),
    .hit_o(cyc_hit)
  ); // R6 R7

  assign ovf = wrap_hit | cyc_hit;

  // fine value: wraps times taps plus current tap
  assign fine_now = FINE_W'(wrap_cnt_r) * RING_TAPS + FINE_W'(phase_s); // R1

  assign fine_latch = ring_on & ~ovf & (ctrl_mode_r ? ref_rise : stop_rise); // R10
  assign cyc_latch = (state_r == TOFC_CLOCK) & ~ovf & stop_rise;
  assign last_fine = ctrl_mode_r ? (stop_idx_r == num_stop) : (fine_idx_r == num_stop - 3'h1);
  assign done_ev = fine_latch & last_fine;

  // measurement sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TOFC_IDLE: begin
        if (meas_go) begin
          state_nxt = TOFC_ARMED;
        end
      end
      TOFC_ARMED: begin
        if (start_rise) begin
          state_nxt = TOFC_RING;
        end
      end
      TOFC_RING: begin
        if (ovf) begin
          state_nxt = TOFC_IDLE; // R8
        end else if (done_ev) begin
          state_nxt = TOFC_IDLE;
        end else if (fine_latch && ctrl_mode_r) begin
          state_nxt = TOFC_CLOCK;
        end
      end
      TOFC_CLOCK: begin
        if (ovf) begin
          state_nxt = TOFC_IDLE; // R8
        end else if (stop_rise) begin
          state_nxt = TOFC_RING;
        end
      end
      default: begin
        state_nxt = TOFC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= TOFC_IDLE;
    end else if (clr) begin
      state_r <= TOFC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // wrap counter of the ring oscillator
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wrap_cnt_r <= '0;
    end else if (clr || state_nxt != TOFC_RING) begin
      wrap_cnt_r <= '0;
    end else if (fine_latch && ctrl_mode_r) begin
      wrap_cnt_r <= '0;
    end else if (ring_on && wrap_tick) begin
      wrap_cnt_r <= wrap_cnt_r + 16'h0001; // R1
    end
  end

  // reference cycle counter, long-range mode only
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cyc_cnt_r <= '0;
      clk_run_r <= 1'b0;
    end else if (clr || state_nxt == TOFC_IDLE || state_r == TOFC_ARMED) begin
      cyc_cnt_r <= '0;
      clk_run_r <= 1'b0;
    end else if (ctrl_mode_r && ref_rise) begin
      clk_run_r <= 1'b1; // R2
      if (clk_run_r) begin
        cyc_cnt_r <= cyc_cnt_r + 16'h0001; // R2
      end
    end
  end

  // result capture
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fine_idx_r <= '0;
      stop_idx_r <= '0;
      for (int i = 0; i < NUM_FINE; i++) begin
        fine_res_r[i] <= '0;
      end
      for (int i = 0; i < NUM_STOP; i++) begin
        cyc_res_r[i] <= '0;
      end
    end else if (clr || (state_r == TOFC_ARMED && start_rise)) begin
      fine_idx_r <= '0;
      stop_idx_r <= '0;
      for (int i = 0; i < NUM_FINE; i++) begin
        fine_res_r[i] <= '0;
      end
      for (int i = 0; i < NUM_STOP; i++) begin
        cyc_res_r[i] <= '0;
      end
    end else begin
      if (fine_latch && fine_idx_r < 3'(NUM_FINE)) begin
        fine_res_r[fine_idx_r] <= fine_now; // R1
        fine_idx_r <= fine_idx_r + 3'h1;
      end
      if (cyc_latch && stop_idx_r < 3'(NUM_STOP)) begin
        cyc_res_r[stop_idx_r] <= cyc_cnt_r; // R3
        stop_idx_r <= stop_idx_r + 3'h1;
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_mode_r <= CTRL_MODE_RST;
      ctrl_nstop_r <= CTRL_NSTOP_RST;
      int_mask_r <= INT_MASK_RST;
      wrap_lim_high_r <= LIM_BYTE_RST;
      wrap_lim_low_r <= LIM_BYTE_RST;
      cyc_lim_high_r <= LIM_BYTE_RST;
      cyc_lim_low_r <= LIM_BYTE_RST;
    end else if (clr) begin
      ctrl_mode_r <= CTRL_MODE_RST;
      ctrl_nstop_r <= CTRL_NSTOP_RST;
      int_mask_r <= INT_MASK_RST;
      wrap_lim_high_r <= LIM_BYTE_RST;
      wrap_lim_low_r <= LIM_BYTE_RST;
      cyc_lim_high_r <= LIM_BYTE_RST;
      cyc_lim_low_r <= LIM_BYTE_RST;
    end else if (reg_we_i) begin // R12
      case (reg_addr_i)
        OFS_CTRL: begin
          ctrl_mode_r <= reg_wdata_i[CTRL_MODE_BIT];
          ctrl_nstop_r <= reg_wdata_i[CTRL_NSTOP_LSB +: IDX_W];
        end
        OFS_INT_MASK: int_mask_r <= reg_wdata_i[INT_W-1:0];
        OFS_WRAP_LIM_HIGH: wrap_lim_high_r <= reg_wdata_i[BYTE_W-1:0];
        OFS_WRAP_LIM_LOW: wrap_lim_low_r <= reg_wdata_i[BYTE_W-1:0];
        OFS_CYC_LIM_HIGH: cyc_lim_high_r <= reg_wdata_i[BYTE_W-1:0];
        OFS_CYC_LIM_LOW: cyc_lim_low_r <= reg_wdata_i[BYTE_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // sticky interrupt status; a set in the clearing cycle wins
  always_comb begin
    int_ev = '0;
    int_ev[INT_DONE_BIT] = done_ev;
    int_ev[INT_WRAP_BIT] = wrap_hit; // R4
    int_ev[INT_CYC_BIT] = cyc_hit; // R6
    int_w1c = '0;
    if (reg_we_i && reg_addr_i == OFS_INT_STATUS) begin
      int_w1c = reg_wdata_i[INT_W-1:0];
    end
    if (meas_go) begin
      int_w1c = '1; // R14
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      int_status_r <= '0;
    end else if (clr) begin
      int_status_r <= '0;
    end else begin
      int_status_r <= (int_status_r & ~int_w1c) | int_ev; // R14
    end
  end

  assign irq_o = |(int_status_r & int_mask_r);

  // read port: data stand only in the cycle after the strobe
  assign fine_ofs = reg_addr_i - OFS_FINE_FIRST;
  assign cyc_ofs = reg_addr_i - OFS_CYC_FIRST;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_r <= '0;
    end else if (clr || !reg_re_i) begin // R13
      rdata_r <= '0;
    end else if (reg_addr_i >= OFS_FINE_FIRST && fine_ofs < ADDR_W'(NUM_FINE)) begin
      rdata_r <= DATA_W'(fine_res_r[fine_ofs[IDX_W-1:0]]);
    end else if (reg_addr_i >= OFS_CYC_FIRST && cyc_ofs < ADDR_W'(NUM_STOP)) begin
      rdata_r <= DATA_W'(cyc_res_r[cyc_ofs[IDX_W-1:0]]); // R3
    end else begin
      case (reg_addr_i)
        OFS_CTRL: rdata_r <= DATA_W'({ctrl_nstop_r, ctrl_mode_r, 1'b0});
        OFS_INT_STATUS: rdata_r <= DATA_W'(int_status_r);
        OFS_INT_MASK: rdata_r <= DATA_W'(int_mask_r);
        OFS_WRAP_LIM_HIGH: rdata_r <= DATA_W'(wrap_lim_high_r);
        OFS_WRAP_LIM_LOW: rdata_r <= DATA_W'(wrap_lim_low_r);
        OFS_CYC_LIM_HIGH: rdata_r <= DATA_W'(cyc_lim_high_r);
        OFS_CYC_LIM_LOW: rdata_r <= DATA_W'(cyc_lim_low_r);
        OFS_STATE: rdata_r <= DATA_W'({ready_r, ctrl_mode_r, state_r});
        default: rdata_r <= '0;
      endcase
    end
  end

  assign reg_rdata_o = rdata_r;
endmodule : tofc_core

// [hw/tofc_pkg.sv]
/*
  tofc_pkg: shared constants of the stopwatch counting core: register
  offsets, field positions, reset values, timing counts and the state type.
  Assumes the core runs on a 100 MHz clock.
*/
package tofc_pkg;

  // data path widths
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int FINE_W = 23;
  localparam int LIM_W = 16;
  localparam int BYTE_W = 8;
  localparam int PHASE_W = 6;
  localparam int NUM_STOP = 5;
  localparam int NUM_FINE = 6;
  localparam int IDX_W = 3;
  localparam int INT_W = 3;

  // ring oscillator taps per wrap; result over taps gives the wrap count
  localparam logic [FINE_W-1:0] RING_TAPS = 23'h00003f;
  localparam int LIMIT_SHIFT = 8;

  // register offsets (word addresses)
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 6'h01;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 6'h02;
  localparam logic [ADDR_W-1:0] OFS_WRAP_LIM_HIGH = 6'h03;
  localparam logic [ADDR_W-1:0] OFS_WRAP_LIM_LOW = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_CYC_LIM_HIGH = 6'h05;
  localparam logic [ADDR_W-1:0] OFS_CYC_LIM_LOW = 6'h06;
  localparam logic [ADDR_W-1:0] OFS_STATE = 6'h07;
  localparam logic [ADDR_W-1:0] OFS_FINE_FIRST = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_CYC_FIRST = 6'h18;

  // control register fields
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_NSTOP_LSB = 2;

  // interrupt status / mask fields
  localparam int INT_DONE_BIT = 0;
  localparam int INT_WRAP_BIT = 1;
  localparam int INT_CYC_BIT = 2;

  // state register fields
  localparam int STATE_READY_BIT = 3;
  localparam int STATE_MODE_BIT = 2;

  // reset values
  localparam logic CTRL_MODE_RST = 1'b0;
  localparam logic [IDX_W-1:0] CTRL_NSTOP_RST = 3'h1;
  localparam logic [INT_W-1:0] INT_MASK_RST = 3'h0;
  localparam logic [BYTE_W-1:0] LIM_BYTE_RST = 8'hff;

  // settle time of the fine time base after enable
  localparam int WAKE_US = 300;
  localparam int CLK_MHZ = 100;
  localparam int WAKE_CYCLES = WAKE_US * CLK_MHZ;

  typedef enum logic [1:0] {
    TOFC_IDLE = 2'b00,
    TOFC_ARMED = 2'b01,
    TOFC_RING = 2'b10,
    TOFC_CLOCK = 2'b11
  } tofc_state_type;

endpackage : tofc_pkg

// [hw/tofc_sync.sv]
/*
  tofc_sync: two flip-flop synchroniser, one pair per bit.
  Assumes each bit is a level that stays put for several clocks.
*/
`timescale 1ns/1ns
module tofc_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,          // core clock
  input wire logic reset_i,        // async reset, active high
  input wire logic [W-1:0] d_i,    // asynchronous input
  output logic [W-1:0] q_o         // synchronised level
);
  logic [W-1:0] meta_r;
  logic [W-1:0] hold_r;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_r <= '0;
      hold_r <= '0;
    end else begin
      meta_r <= d_i;
      hold_r <= meta_r;
    end
  end

  assign q_o = hold_r;
endmodule : tofc_sync

// [hw/tofc_limit_cmp.sv]
/*
  tofc_limit_cmp: compares a running count with a limit built from a high
  and a low byte. STRICT selects greater-than instead of greater-or-equal.
  Assumes all inputs come from the same clock domain.
*/
`timescale 1ns/1ns
module tofc_limit_cmp
  import tofc_pkg::*;
#(
  parameter bit STRICT = 1'b0
) (
  input wire logic active_i,                    // counter is running
  input wire logic [LIM_W-1:0] count_i,         // running count
  input wire logic [BYTE_W-1:0] limit_high_i,   // limit, upper byte
  input wire logic [BYTE_W-1:0] limit_low_i,    // limit, lower byte
  output logic hit_o                            // count reached the limit, or passed it if STRICT
);
  logic [LIM_W-1:0] limit;

  // high byte times 2^8 plus low byte
  assign limit = {limit_high_i, limit_low_i};
  assign hit_o = active_i & (STRICT ? (count_i > limit) : (count_i >= limit));
endmodule : tofc_limit_cmp

// [dv/tofc_core_sva.sv]
/*
  tofc_core_sva: port-level checks of the counting core.
  Assumes it is bound onto tofc_core and sees only its ports.
*/
`timescale 1ns/1ns
module tofc_core_sva #(
  parameter int WAKE_CYC = 20
) (
  input wire logic clk_i,                                  // core clock
  input wire logic reset_i,                                // async reset
  input wire logic enable_i,                               // enable pin
  input wire logic start_i,                                // start pin
  input wire logic stop_i,                                 // stop pin
  input wire logic ref_clk_i,                              // reference clock
  input wire logic ring_wrap_i,                            // wrap toggle
  input wire logic [tofc_pkg::PHASE_W-1:0] ring_phase_i,   // ring tap
  input wire logic [tofc_pkg::ADDR_W-1:0] reg_addr_i,      // address
  input wire logic [tofc_pkg::DATA_W-1:0] reg_wdata_i,     // write data
  input wire logic reg_we_i,                               // write strobe
  input wire logic reg_re_i,                               // read strobe
  input wire logic [tofc_pkg::DATA_W-1:0] reg_rdata_o,     // read data
  input wire logic irq_o                                   // interrupt
);
  import tofc_pkg::*;
  logic [2:0] en_q;
  logic en_ok;
  logic is_lim;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // enable seen high long enough to pass the synchroniser
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      en_q <= 3'h0;
    end else begin
      en_q <= {en_q[1:0], enable_i};
    end
  end
  assign en_ok = enable_i && (&en_q);
  assign is_lim = reg_addr_i >= OFS_WRAP_LIM_HIGH && reg_addr_i <= OFS_CYC_LIM_LOW;
  rd_idle_zero_a: assert property (!reg_re_i |=> reg_rdata_o == '0)
    else $error("read data not zero outside a read");
  lim_readback_a: assert property (reg_we_i && is_lim && en_ok ##1 !reg_we_i ##1
    reg_re_i && reg_addr_i == $past(reg_addr_i, 2)
    |=> reg_rdata_o == {24'h0, $past(reg_wdata_i[7:0], 3)})
    else $error("limit byte read back wrong");
  en_low_read_a: assert property (!enable_i [*3] ##0 reg_re_i |=> reg_rdata_o == '0)
    else $error("read taken while disabled");
  mask_off_a: assert property (reg_we_i && en_ok && reg_addr_i == OFS_INT_MASK &&
    reg_wdata_i[INT_W-1:0] == '0 |=> !irq_o)
    else $error("interrupt high with mask cleared");
  go_clear_a: assert property (reg_we_i && en_ok && reg_addr_i == OFS_CTRL &&
    reg_wdata_i[CTRL_GO_BIT] |=> !irq_o)
    else $error("start command left flags set");
  w1c_clear_a: assert property (reg_we_i && en_ok && reg_addr_i == OFS_INT_STATUS &&
    reg_wdata_i[INT_W-1:0] == 3'h7 |=> !irq_o)
    else $error("write one did not clear flags");
  flag_hold_a: assert property (irq_o && en_ok && !reg_we_i |=> irq_o)
    else $error("interrupt dropped without a clear");
  cyc_width_a: assert property (reg_re_i && reg_addr_i >= OFS_CYC_FIRST &&
    reg_addr_i < OFS_CYC_FIRST + ADDR_W'(NUM_STOP) |=> reg_rdata_o[DATA_W-1:LIM_W] == '0)
    else $error("cycle result wider than 16 bits");
  fine_width_a: assert property (reg_re_i && reg_addr_i >= OFS_FINE_FIRST &&
    reg_addr_i < OFS_FINE_FIRST + ADDR_W'(NUM_FINE) |=> reg_rdata_o[DATA_W-1:FINE_W] == '0)
    else $error("fine result wider than 23 bits");
  cover property ($rose(irq_o));
  cover property (reg_re_i && reg_addr_i == OFS_CYC_FIRST);
  cover property ($fell(enable_i));
endmodule : tofc_core_sva

bind tofc_core tofc_core_sva #(.WAKE_CYC(WAKE_CYC)) u_sva (
  .clk_i(clk_i), .reset_i(reset_i), .enable_i(enable_i), .start_i(start_i), .stop_i(stop_i),
  .ref_clk_i(ref_clk_i), .ring_wrap_i(ring_wrap_i), .ring_phase_i(ring_phase_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
  .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o)
);

// [dv/tofc_far_model.sv]
/*
  tofc_far_model: far side of the core: reference clock, ring wraps and
  start/stop pulses. Assumes the bench calls its tasks.
*/
`timescale 1ns/1ns
module tofc_far_model #(
  parameter int REF_HALF = 80
) (
  input wire logic enable_i,  // device enable level
  output logic ref_clk_o,     // reference clock
  output logic ring_wrap_o,   // toggles once per wrap
  output logic start_o,       // start pin
  output logic stop_o         // stop pin
);
  initial begin
    ring_wrap_o = 1'b0;
    start_o = 1'b0;
    stop_o = 1'b0;
  end
  // runs free while enabled, parked low otherwise
  always begin
    ref_clk_o = 1'b0;
    #(REF_HALF);
    ref_clk_o = enable_i;
    #(REF_HALF);
  end
  // pulses held long enough for the two flip-flop synchroniser
  task automatic pulse_start();
    start_o = 1'b1;
    #50;
    start_o = 1'b0;
    #50;
  endtask : pulse_start
  task automatic pulse_stop();
    stop_o = 1'b1;
    #50;
    stop_o = 1'b0;
    #50;
  endtask : pulse_stop
  task automatic wraps(input int n);
    repeat (n) begin
      ring_wrap_o = ~ring_wrap_o;
      #40;
    end
  endtask : wraps
endmodule : tofc_far_model

// [dv/tofc_core_bench.sv]
/*
  tofc_core_bench: self-checking bench of the counting core.
  Assumes tofc_far_model drives the pins and the checker is bound.
*/
`timescale 1ns/1ns
module tofc_core_bench;
  import tofc_pkg::*;
  localparam int WAKE_SIM = 20;
  typedef struct {
    string name;
    logic [DATA_W-1:0] exp;
  } tofc_note_type;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic enable_i = 1'b1;
  logic ref_clk, ring_wrap, start, stop;
  logic [PHASE_W-1:0] ring_phase_i = '0;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [DATA_W-1:0] reg_rdata_o;
  logic irq_o;
  logic rd_pend = 1'b0;
  logic [31:0] seed = 32'hd447e811;
  logic [PHASE_W-1:0] ph;
  int failures = 0;
  int total_checks = 0;
  tofc_note_type notes[$];
  tofc_note_type n;

  always #5 clk_i = ~clk_i;

  tofc_core #(.WAKE_CYC(WAKE_SIM)) dut (
    .clk_i(clk_i), .reset_i(reset_i), .enable_i(enable_i), .start_i(start), .stop_i(stop),
    .ref_clk_i(ref_clk), .ring_wrap_i(ring_wrap), .ring_phase_i(ring_phase_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o)
  );
  tofc_far_model u_far (
    .enable_i(enable_i), .ref_clk_o(ref_clk), .ring_wrap_o(ring_wrap), .start_o(start),
    .stop_o(stop)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask : wr

  // note the expectation, then issue the one-cycle read
  task automatic rd(input logic [ADDR_W-1:0] a, input string name, input logic [31:0] e);
    tofc_note_type t;
    t.name = name;
    t.exp = e;
    notes.push_back(t);
    @(posedge clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
  endtask : rd

  task automatic ref_edges(input int k);
    repeat (k) @(posedge ref_clk);
    #80;
  endtask : ref_edges

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask : tend

  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // read data stands only in the cycle after the strobe
  always @(posedge clk_i) begin
    if (rd_pend) begin
      n = notes.pop_front();
      check(n.name, reg_rdata_o, n.exp);
    end
    rd_pend <= reg_re_i;
  end

  initial begin
    #200000;
    failures++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (WAKE_SIM + 8) @(posedge clk_i);
    rd(OFS_STATE, "state ready", 32'h8);
    rd(OFS_WRAP_LIM_HIGH, "wrap limit high rst", 32'hff);
    rd(OFS_CYC_LIM_LOW, "cycle limit low rst", 32'hff);
    rd(OFS_INT_MASK, "mask rst", 32'h0);
    wr(6'h3f, 32'h5a);
    rd(6'h3f, "unmapped", 32'h0);
    wr(OFS_WRAP_LIM_HIGH, 32'h0);
    rd(OFS_WRAP_LIM_HIGH, "wrap limit high", 32'h0);
    wr(OFS_WRAP_LIM_LOW, 32'h3);
    rd(OFS_WRAP_LIM_LOW, "wrap limit low", 32'h3);
    tend("registers");
    seed = xs(seed);
    ph = PHASE_W'(seed % 63);
    ring_phase_i <= ph;
    wr(OFS_CTRL, 32'h1); // stop field 0 clamps to one stop
    u_far.pulse_start();
    u_far.wraps(2);
    u_far.pulse_stop();
    repeat (8) @(posedge clk_i);
    rd(OFS_FINE_FIRST, "fine first", 32'(2 * 63 + ph));
    rd(OFS_INT_STATUS, "status below limit", 32'h1);
    #1 check("irq masked", irq_o, 32'h0);
    wr(OFS_INT_MASK, 32'h7);
    #1 check("irq raised", irq_o, 32'h1);
    wr(OFS_INT_MASK, 32'h0);
    #1 check("irq mask off", irq_o, 32'h0);
    wr(OFS_INT_MASK, 32'h7);
    wr(OFS_INT_STATUS, 32'h7);
    #1 check("irq cleared", irq_o, 32'h0);
    tend("short range");
    wr(OFS_CTRL, 32'h5);
    u_far.pulse_start();
    u_far.wraps(3);
    repeat (8) @(posedge clk_i);
    rd(OFS_INT_STATUS, "wrap limit hit", 32'h2);
    rd(OFS_STATE, "idle after wrap limit", 32'h8);
    u_far.pulse_stop();
    rd(OFS_INT_STATUS, "flag kept", 32'h2);
    tend("wrap limit");
    wr(OFS_CYC_LIM_HIGH, 32'h1);
    wr(OFS_CYC_LIM_LOW, 32'h0);
    wr(OFS_CTRL, 32'hb);
    @(posedge ref_clk);
    #40;
    u_far.pulse_start();
    ref_edges(4);
    u_far.pulse_stop();
    ref_edges(1);
    u_far.pulse_stop();
    repeat (8) @(posedge clk_i);
    rd(OFS_CYC_FIRST, "cycle count first", 32'h3);
    rd(OFS_CYC_FIRST + 6'h1, "cycle count second", 32'h5);
    rd(OFS_INT_STATUS, "long range done", 32'h1);
    tend("long range");
    wr(OFS_CYC_LIM_HIGH, 32'h0);
    wr(OFS_CYC_LIM_LOW, 32'h2);
    wr(OFS_CTRL, 32'h7);
    @(posedge ref_clk);
    #40;
    u_far.pulse_start();
    ref_edges(3);
    rd(OFS_INT_STATUS, "cycle count at limit", 32'h0);
    rd(OFS_STATE, "still counting", 32'hf);
    ref_edges(1);
    rd(OFS_INT_STATUS, "cycle limit hit", 32'h4);
    rd(OFS_STATE, "idle after cycle limit", 32'hc);
    tend("cycle limit");
    enable_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(OFS_CYC_LIM_LOW, "read while disabled", 32'h0);
    enable_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rd(OFS_CYC_LIM_LOW, "limit after enable", 32'hff);
    rd(OFS_INT_STATUS, "status after enable", 32'h0);
    tend("enable");
    repeat (4) @(posedge clk_i);
    print_verdict();
  end
endmodule : tofc_core_bench
